// ===== src/comm_io_status_indicator_driver.sv
`timescale 1ns/1ps
module comm_io_status_indicator_driver #(
  parameter int unsigned UNIT_CYC = lamp_pkg::UNIT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [lamp_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic eth_link_up,
  input wire logic eth_speed_100,
  input wire logic eth_activity,
  input wire logic [1:0] can_state,
  input wire logic can_warn,
  input wire logic can_slave_offline,
  input wire logic can_bus_off,
  input wire logic rs232_tx_active,
  input wire logic rs485_tx_active,
  input wire logic [lamp_pkg::N_IN-1:0] din,
  input wire logic [lamp_pkg::N_OUT-1:0] dout,
  output logic lamp_eth_green,
  output logic lamp_eth_yellow,
  output logic lamp_can_run,
  output logic lamp_can_err,
  output logic lamp_rs232,
  output logic lamp_rs485,
  output logic [lamp_pkg::N_IN-1:0] lamp_in,
  output logic [lamp_pkg::N_OUT-1:0] lamp_out
);
  import lamp_pkg::*;

  localparam logic [CNT_W-1:0] UNIT_LAST = CNT_W'(UNIT_CYC - 1);
  localparam logic [SEQ_W-1:0] SINGLE_LAST = SEQ_W'(SINGLE_LEN - 1);
  localparam logic [SEQ_W-1:0] DOUBLE_LAST = SEQ_W'(DOUBLE_LEN - 1);
  localparam logic [SEQ_W-1:0] ON_U = SEQ_W'(ON_UNITS);
  localparam logic [SEQ_W-1:0] GAP_U = SEQ_W'(GAP_UNITS);
  localparam logic [SEQ_W-1:0] BLINK_U = SEQ_W'(BLINK_UNITS);
  localparam logic [SEQ_W-1:0] SECOND_ON = SEQ_W'(ON_UNITS + GAP_UNITS);
  localparam logic [SEQ_W-1:0] SECOND_OFF = SEQ_W'(2 * ON_UNITS + GAP_UNITS);

  ////////////////////////////////////////////////////////////////////////
  // pattern time base

  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [SEQ_W-1:0] single_r, single_nxt;
  logic [SEQ_W-1:0] double_r, double_nxt;
  logic [SEQ_W-1:0] blink_cnt_r, blink_cnt_nxt;
  logic blink_r, blink_nxt;
  logic unit_end;

  // unit counter: one wrap per pattern unit
  always_comb begin
    unit_end = (cnt_r == UNIT_LAST);
    if (unit_end) begin
      cnt_nxt = '0;
    end else begin
      cnt_nxt = cnt_r + 1'b1;
    end
    single_nxt = single_r;
    double_nxt = double_r;
    blink_cnt_nxt = blink_cnt_r;
    blink_nxt = blink_r;
    if (unit_end) begin
      // flash phase counters wrap at group end
      if (single_r == SINGLE_LAST) begin
        single_nxt = '0;
      end else begin
        single_nxt = single_r + 1'b1;
      end
      if (double_r == DOUBLE_LAST) begin
        double_nxt = '0;
      end else begin
        double_nxt = double_r + 1'b1;
      end
      // blink phase flips every BLINK_U units
      if (blink_cnt_r == BLINK_U - 1'b1) begin
        blink_cnt_nxt = '0;
        blink_nxt = ~blink_r;
      end else begin
        blink_cnt_nxt = blink_cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_r <= '0;
      single_r <= '0;
      double_r <= '0;
      blink_cnt_r <= '0;
      blink_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      single_r <= single_nxt;
      double_r <= double_nxt;
      blink_cnt_r <= blink_cnt_nxt;
      blink_r <= blink_nxt;
    end
  end

  // flash shapes: on for one unit, gap, second flash, long off
  logic single_on, double_on;
  always_comb begin
    single_on = (single_r < ON_U);
    double_on = (double_r < ON_U) ||
                ((double_r >= SECOND_ON) && (double_r < SECOND_OFF));
  end

  ////////////////////////////////////////////////////////////////////////
  // traffic hold: a short burst keeps the lamp blinking to unit end

  logic [N_ACT-1:0] act_in, act_r, act_nxt;
  always_comb begin
    act_in = {rs485_tx_active, rs232_tx_active, eth_activity};
    // new activity wins over the unit-end clear
    if (unit_end) begin
      act_nxt = act_in;
    end else begin
      act_nxt = act_r | act_in;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      act_r <= '0;
    end else begin
      act_r <= act_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register file

  logic [1:0] ctrl_r, ctrl_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic req;
  logic [31:0] stat_word, point_word;
  fault_e fault;

  always_comb begin
    req = avs_read | avs_write;
    // one wait state: ack_r marks the answer cycle
    avs_waitrequest = req & ~ack_r;
    ack_nxt = req & ~ack_r;
    // status word assembled from live lamp state
    stat_word = '0;
    stat_word[ST_ETH_G_BIT] = lamp_eth_green;
    stat_word[ST_ETH_Y_BIT] = lamp_eth_yellow;
    stat_word[ST_RUN_BIT] = lamp_can_run;
    stat_word[ST_ERR_BIT] = lamp_can_err;
    stat_word[ST_232_BIT] = lamp_rs232;
    stat_word[ST_485_BIT] = lamp_rs485;
    stat_word[ST_FAULT_LSB +: 2] = fault;
    point_word = '0;
    point_word[PT_IN_LSB +: N_IN] = lamp_in;
    point_word[PT_OUT_LSB +: N_OUT] = lamp_out;
    ctrl_nxt = ctrl_r;
    rdata_nxt = rdata_r;
    // write lands on the edge that sees waitrequest low
    if (avs_write && ack_r) begin
      if (avs_address == CTRL_OFS && avs_byteenable[0]) begin
        ctrl_nxt = avs_writedata[1:0];
      end
    end
    // read word registered in the wait cycle, stands until next read
    if (req && !ack_r) begin
      if (avs_read) begin
        // unmapped reads return zero
        case (avs_address)
          CTRL_OFS: rdata_nxt = {30'h0, ctrl_r};
          STAT_OFS: rdata_nxt = stat_word;
          POINT_OFS: rdata_nxt = point_word;
          default: rdata_nxt = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_r <= CTRL_RST;
      ack_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign avs_readdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////
  // lamp decode

  logic lamp_en, lamp_test;
  logic eth_g_nxt, eth_y_nxt, run_nxt;
  logic err_nxt, s232_nxt, s485_nxt;
  logic [N_IN-1:0] in_nxt;
  logic [N_OUT-1:0] out_nxt;

  always_comb begin
    // control bits: enable and lamp test
    lamp_en = ctrl_r[CTRL_EN_BIT];
    lamp_test = ctrl_r[CTRL_TEST_BIT];
    // worst fault first
    if (can_bus_off) begin
      fault = FLT_BUSOFF;
    end else if (can_slave_offline) begin
      fault = FLT_OFFLINE;
    end else if (can_warn) begin
      fault = FLT_WARN;
    end else begin
      fault = FLT_NONE;
    end
    eth_g_nxt = eth_link_up & eth_speed_100;
    eth_y_nxt = act_r[0] & blink_r;
    case (can_state_e'(can_state))
      CAN_STOPPED: run_nxt = single_on;
      CAN_PREOP: run_nxt = blink_r;
      CAN_OPER: run_nxt = 1'b1;
      default: run_nxt = 1'b0;
    endcase
    case (fault)
      FLT_BUSOFF: err_nxt = 1'b1;
      FLT_OFFLINE: err_nxt = double_on;
      FLT_WARN: err_nxt = single_on;
      default: err_nxt = 1'b0;
    endcase
    s232_nxt = act_r[1] & blink_r;
    s485_nxt = act_r[2] & blink_r;
    in_nxt = din;
    out_nxt = dout;
    // lamp test lights all, blanking applies only when not testing
    if (lamp_test) begin
      eth_g_nxt = 1'b1;
      eth_y_nxt = 1'b1;
      run_nxt = 1'b1;
      err_nxt = 1'b1;
      s232_nxt = 1'b1;
      s485_nxt = 1'b1;
      in_nxt = '1;
      out_nxt = '1;
    end else if (!lamp_en) begin
      eth_g_nxt = 1'b0;
      eth_y_nxt = 1'b0;
      run_nxt = 1'b0;
      err_nxt = 1'b0;
      s232_nxt = 1'b0;
      s485_nxt = 1'b0;
      in_nxt = '0;
      out_nxt = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lamp_eth_green <= 1'b0;
      lamp_eth_yellow <= 1'b0;
      lamp_can_run <= 1'b0;
      lamp_can_err <= 1'b0;
      lamp_rs232 <= 1'b0;
      lamp_rs485 <= 1'b0;
      lamp_in <= '0;
      lamp_out <= '0;
    end else begin
      lamp_eth_green <= eth_g_nxt;
      lamp_eth_yellow <= eth_y_nxt;
      lamp_can_run <= run_nxt;
      lamp_can_err <= err_nxt;
      lamp_rs232 <= s232_nxt;
      lamp_rs485 <= s485_nxt;
      lamp_in <= in_nxt;
      lamp_out <= out_nxt;
    end
  end

endmodule : comm_io_status_indicator_driver

// ===== pkg/lamp_pkg.sv
package lamp_pkg;

  // system clock rate
  localparam int unsigned CLK_HZ = 20_000_000;

  // flash timing in milliseconds
  localparam int unsigned FLASH_ON_MS = 200;
  localparam int unsigned FLASH_GAP_MS = 200;
  localparam int unsigned GROUP_OFF_MS = 1000;
  localparam int unsigned BLINK_MS = 200;

  // cycles per 200 ms unit, rounded down
  localparam int unsigned UNIT_CYCLES = (CLK_HZ / 1000) * FLASH_ON_MS;
  // units per pattern section
  localparam int unsigned ON_UNITS = FLASH_ON_MS / FLASH_ON_MS;
  localparam int unsigned GAP_UNITS = FLASH_GAP_MS / FLASH_ON_MS;
  localparam int unsigned OFF_UNITS = GROUP_OFF_MS / FLASH_ON_MS;
  localparam int unsigned BLINK_UNITS = BLINK_MS / FLASH_ON_MS;
  localparam int unsigned SINGLE_LEN = ON_UNITS + OFF_UNITS;
  localparam int unsigned DOUBLE_LEN = 2 * ON_UNITS + GAP_UNITS + OFF_UNITS;

  localparam int CNT_W = 23;
  localparam int SEQ_W = 4;

  // register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic [3:0] POINT_OFS = 4'h8;
  localparam int ADDR_W = 4;

  // control register fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_TEST_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;

  // status register fields
  localparam int ST_ETH_G_BIT = 0;
  localparam int ST_ETH_Y_BIT = 1;
  localparam int ST_RUN_BIT = 2;
  localparam int ST_ERR_BIT = 3;
  localparam int ST_232_BIT = 4;
  localparam int ST_485_BIT = 5;
  localparam int ST_FAULT_LSB = 8;

  // point register fields
  localparam int PT_IN_LSB = 0;
  localparam int PT_OUT_LSB = 16;

  localparam int N_IN = 16;
  localparam int N_OUT = 8;
  localparam int N_ACT = 3;

  typedef enum logic [1:0] {
    CAN_STOPPED = 2'b00,
    CAN_PREOP = 2'b01,
    CAN_OPER = 2'b10,
    CAN_OTHER = 2'b11
  } can_state_e;

  typedef enum logic [1:0] {
    FLT_NONE = 2'b00,
    FLT_WARN = 2'b01,
    FLT_OFFLINE = 2'b10,
    FLT_BUSOFF = 2'b11
  } fault_e;

endpackage : lamp_pkg

// ===== verification/lamp_panel.sv
`timescale 1ns/1ps
module lamp_panel (
  input wire logic clk_sys,
  input wire logic clr,
  input wire logic [5:0] lamps,
  output logic [5:0][7:0] rises
);
  logic [5:0] prev_r;
  // operator sees one flash per dark-to-lit edge
  always_ff @(posedge clk_sys) begin
    prev_r <= lamps;
    for (int i = 0; i < 6; i++) begin
      rises[i] <= clr ? 8'h00 : rises[i] + 8'(lamps[i] & ~prev_r[i]);
    end
  end
endmodule : lamp_panel

// ===== verification/lamp_monitor.sv
`timescale 1ns/1ps
module lamp_monitor
  import lamp_pkg::*;
#(
  parameter int unsigned UNIT_CYC = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic eth_link_up,
  input wire logic eth_speed_100,
  input wire logic eth_activity,
  input wire logic [1:0] can_state,
  input wire logic can_warn,
  input wire logic can_slave_offline,
  input wire logic can_bus_off,
  input wire logic rs232_tx_active,
  input wire logic rs485_tx_active,
  input wire logic [15:0] din,
  input wire logic [7:0] dout,
  input wire logic lamp_eth_green,
  input wire logic lamp_eth_yellow,
  input wire logic lamp_can_run,
  input wire logic lamp_can_err,
  input wire logic lamp_rs232,
  input wire logic lamp_rs485,
  input wire logic [15:0] lamp_in,
  input wire logic [7:0] lamp_out
);
  logic [1:0] ctrl_r;
  logic [1:0] quiet_r;
  logic [9:0] idle_r;
  logic ok;
  // checks paused near writes and outside normal mode
  assign ok = quiet_r == 2'h0 && ctrl_r == CTRL_RST;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_r <= CTRL_RST;
      quiet_r <= 2'h3;
      idle_r <= 10'h000;
    end else begin
      quiet_r <= avs_write ? 2'h3 : quiet_r - 2'(quiet_r != 2'h0);
      if (avs_write && !avs_waitrequest && avs_address == CTRL_OFS
          && avs_byteenable[0]) begin
        ctrl_r <= avs_writedata[1:0];
      end
      if (eth_activity || rs232_tx_active || rs485_tx_active) begin
        idle_r <= 10'h000;
      end else if (idle_r != 10'h3FF) begin
        idle_r <= idle_r + 10'h001;
      end
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  eth_green_a: assert property (ok |=>
    lamp_eth_green == $past(eth_link_up && eth_speed_100))
    else $error("ethernet green lamp wrong");
  run_steady_a: assert property (ok && can_state == CAN_OPER |=>
    lamp_can_run) else $error("run lamp not steady");
  run_dark_a: assert property (ok && can_state == CAN_OTHER |=>
    !lamp_can_run) else $error("run lamp lit in other state");
  err_busoff_a: assert property (ok && can_bus_off |=>
    lamp_can_err) else $error("error lamp not steady on bus-off");
  err_clear_a: assert property (ok && !can_warn
    && !can_slave_offline && !can_bus_off |=> !lamp_can_err)
    else $error("error lamp lit");
  points_a: assert property (ok |=> lamp_in == $past(din)
    && lamp_out == $past(dout)) else $error("point lamps wrong");
  activity_quiet_a: assert property (ok
    && idle_r > 2 * UNIT_CYC
    |-> !lamp_eth_yellow && !lamp_rs232 && !lamp_rs485)
    else $error("activity lamp lit while idle");
  bus_wait_a: assert property (avs_write && avs_waitrequest |=>
    !avs_waitrequest) else $error("write not answered");
endmodule : lamp_monitor
bind comm_io_status_indicator_driver lamp_monitor #(.UNIT_CYC(UNIT_CYC))
  mon (.*);

// ===== verification/tb_comm_io_status_indicator_driver.sv
`timescale 1ns/1ps
module tb_comm_io_status_indicator_driver;
  import lamp_pkg::*;
  localparam int unsigned U = 8;
  logic clk_sys = 1'b0, rst = 1'b1, clr = 1'b0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic eth_link_up = 1'b0, eth_speed_100 = 1'b0, eth_activity = 1'b0;
  logic [1:0] can_state = 2'h3;
  logic can_warn = 1'b0, can_slave_offline = 1'b0, can_bus_off = 1'b0;
  logic rs232_tx_active = 1'b0, rs485_tx_active = 1'b0;
  logic [15:0] din = 16'h0, lamp_in;
  logic [7:0] dout = 8'h0, lamp_out;
  logic lamp_eth_green, lamp_eth_yellow, lamp_can_run, lamp_can_err;
  logic lamp_rs232, lamp_rs485;
  logic [5:0][7:0] rises;
  logic [5:0] lv;
  logic [31:0] q;
  int err_count = 0, num_checks = 0, cycles = 0;
  always #25 clk_sys = ~clk_sys;
  comm_io_status_indicator_driver #(.UNIT_CYC(U)) dut (
    .clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .eth_link_up,
    .eth_speed_100, .eth_activity, .can_state, .can_warn,
    .can_slave_offline, .can_bus_off, .rs232_tx_active, .rs485_tx_active,
    .din, .dout, .lamp_eth_green, .lamp_eth_yellow, .lamp_can_run,
    .lamp_can_err, .lamp_rs232, .lamp_rs485, .lamp_in, .lamp_out);
  assign lv = {lamp_rs485, lamp_rs232, lamp_can_err, lamp_can_run,
    lamp_eth_yellow, lamp_eth_green};
  lamp_panel pnl (.clk_sys, .clr, .lamps(lv), .rises);
  ////////////////////////////////////////////////////////////
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task bus(input logic r, input logic [3:0] a, input logic [31:0] d);
    logic w;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= r;
    avs_write <= !r;
    do begin
      @(posedge clk_sys);
      w = avs_waitrequest;
      q = avs_readdata;
    end while (w);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task settle();
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : settle
  // rises of one lamp over 24 units
  task flash(input int i, input logic [7:0] e);
    @(posedge clk_sys);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    repeat (24 * U) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("flashes", {24'h0, e}, {24'h0, rises[i]});
  endtask : flash
  // cycles that one whole flash of lamp i stays lit
  task lit_len(input int i, output int n);
    while (lv[i] === 1'b1) @(negedge clk_sys);
    while (lv[i] !== 1'b1) @(negedge clk_sys);
    n = 0;
    while (lv[i] === 1'b1) begin
      n++;
      @(negedge clk_sys);
    end
  endtask : lit_len
  ////////////////////////////////////////////////////////////
  task t_regs();
    bus(1'b1, CTRL_OFS, 32'h0);
    chk("ctrl", 32'h1, q);
    din <= 16'hA5C3;
    dout <= 8'h3C;
    settle();
    chk("lamp_in", 32'hA5C3, {16'h0, lamp_in});
    chk("lamp_out", 32'h3C, {24'h0, lamp_out});
    bus(1'b1, POINT_OFS, 32'h0);
    chk("point", 32'h003CA5C3, q);
    bus(1'b1, 4'hC, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1'b0, CTRL_OFS, 32'h0);
    settle();
    chk("blank", 32'h0, {16'h0, lamp_in});
    bus(1'b0, CTRL_OFS, 32'h2);
    settle();
    chk("lamp test", 32'hFF, {24'h0, lamp_out});
    bus(1'b0, CTRL_OFS, 32'h1);
    avs_byteenable <= 4'hE;
    bus(1'b0, CTRL_OFS, 32'h0);
    avs_byteenable <= 4'hF;
    bus(1'b0, 4'hC, 32'h0);
    bus(1'b1, CTRL_OFS, 32'h0);
    chk("ctrl", 32'h1, q);
    $display("test regs done");
  endtask : t_regs
  task t_eth();
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      {eth_link_up, eth_speed_100} <= 2'(k);
      settle();
      chk("eth green", {31'h0, k == 3}, {31'h0, lamp_eth_green});
    end
    $display("test eth done");
  endtask : t_eth
  task t_act();
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_sys);
      {eth_activity, rs232_tx_active, rs485_tx_active} <= 3'b100 >> k;
      settle();
      flash(k == 0 ? 1 : k + 3, 8'd12);
      @(posedge clk_sys);
      {eth_activity, rs232_tx_active, rs485_tx_active} <= 3'b000;
      repeat (3 * U) @(posedge clk_sys);
      flash(k == 0 ? 1 : k + 3, 8'd0);
    end
    $display("test activity done");
  endtask : t_act
  task t_run();
    logic [7:0] n [4];
    int m;
    int e;
    n = '{8'd4, 8'd12, 8'd0, 8'd0};
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      can_state <= 2'(k);
      settle();
      flash(2, n[k]);
      if (k < 2) begin
        e = (k == 0) ? ON_UNITS * U : BLINK_UNITS * U;
        lit_len(2, m);
        chk("run on time", e, m);
      end else begin
        chk("run lamp", {31'h0, k == 2}, {31'h0, lamp_can_run});
      end
    end
    $display("test run done");
  endtask : t_run
  task t_err();
    logic [2:0] f [6];
    logic [7:0] n [6];
    logic [1:0] s [6];
    int m;
    f = '{3'd0, 3'd4, 3'd2, 3'd6, 3'd1, 3'd7};
    n = '{8'd0, 8'd4, 8'd6, 8'd6, 8'd0, 8'd0};
    s = '{2'd0, 2'd1, 2'd2, 2'd2, 2'd3, 2'd3};
    for (int k = 0; k < 6; k++) begin
      @(posedge clk_sys);
      {can_warn, can_slave_offline, can_bus_off} <= f[k];
      settle();
      flash(3, n[k]);
      if (k == 0 || k > 3) begin
        chk("err lamp", {31'h0, k > 3}, {31'h0, lamp_can_err});
      end else begin
        lit_len(3, m);
        chk("err on time", ON_UNITS * U, m);
      end
      bus(1'b1, STAT_OFS, 32'h0);
      chk("fault", {30'h0, s[k]}, {30'h0, q[9:8]});
    end
    $display("test error done");
  endtask : t_err
  task results();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 12000) begin
      err_count++;
      $display("FAIL timeout expected finish seen hang");
      results();
    end
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_eth();
    t_act();
    t_run();
    t_err();
    results();
  end
endmodule : tb_comm_io_status_indicator_driver
